/* hdl/quad_dac_i2c_command_decoder.sv */
// Purpose: command decoder for a quad 10-bit converter behind an I2C slave
// Assumes: pins asynchronous to core_clk; SCL far slower than 100 MHz
// Notes:   analog string, amplifier and reference are outside this block
`timescale 1ns/1ps
module quad_dac_i2c_command_decoder
    import qdac_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // Serial bus pins
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n,
    // Strap and control pins
    input  wire logic              addr_select_hi,
    input  wire logic              addr_select_lo,
    input  wire logic              load_strobe_n,
    input  wire logic              gain_sel,
    // Converter side
    output logic [NCH*CODE_W-1:0]  dac_code,
    output logic [NCH*CODE_W-1:0]  input_code,
    output logic [NCH*2-1:0]       power_mode,
    output logic                   ref_disable,
    output logic                   gain_two,
    output logic [NCH-1:0]         load_mask
);
    logic [1:0]   scl_q, sda_q, a1_q, a0_q, ld_q, g_q; // Two-stage synchronisers
    logic         rx_oe_n;            // Receiver drive
    cmd_word_s    word;               // Last complete word
    logic         word_stb;           // Complete word pulse
    logic         ld_fall_r;          // Strobe previous level
    logic         ld_pulse;           // Strobe falling edge
    logic         op_valid;           // Word may act

    // Pin synchronisers, first stage read only by second
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            scl_q <= 2'h3;
            sda_q <= 2'h3;
            a1_q  <= 2'h0;
            a0_q  <= 2'h0;
            ld_q  <= 2'h3;
            g_q   <= 2'h0;
        end else begin
            scl_q <= {scl_q[0], scl_in};
            sda_q <= {sda_q[0], sda_in};
            a1_q  <= {a1_q[0], addr_select_hi};
            a0_q  <= {a0_q[0], addr_select_lo};
            ld_q  <= {ld_q[0], load_strobe_n};
            g_q   <= {g_q[0], gain_sel};
        end
    end

    // slave receiver, oversampled to cover both speeds
    i2c_word_rx u_rx (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .scl_s     (scl_q[1]),
        .sda_s     (sda_q[1]),
        .addr_pins ({a1_q[1], a0_q[1]}),
        .sda_oe_n  (rx_oe_n),
        .word      (word),
        .word_stb  (word_stb)
    );

    // Bus drive registered; output value always low
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sda_out  <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= rx_oe_n;
        end
    end

    // gain follows pin for all channels
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gain_two <= 1'b0;
        end else begin
            gain_two <= g_q[1];
        end
    end

    // Strobe edge for pin-triggered updates
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ld_fall_r <= 1'b1;
        end else begin
            ld_fall_r <= ld_q[1];
        end
    end
    assign ld_pulse = ld_fall_r && !ld_q[1];

    // opcode gates, reserved and empty masks dropped
    assign op_valid = word_stb && !word.opcode[3] && (word.chan_mask != 4'h0);

    // reference on after reset, command may disable
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ref_disable <= REF_RESET_DIS;
        end else if (op_valid && word.opcode == OP_SWRESET) begin
            ref_disable <= REF_RESET_DIS;
        end else if (op_valid && word.opcode == OP_REFSET) begin
            ref_disable <= word.spare[0];
        end
    end

    // Load strobe mask, one bit per channel
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            load_mask <= MASK_RESET;
        end else if (op_valid && word.opcode == OP_SWRESET) begin
            load_mask <= MASK_RESET;
        end else if (op_valid && word.opcode == OP_LDMASK) begin
            load_mask <= word.chan_mask;
        end
    end

    // Per-channel registers
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            logic sel;  // mask bit ch selects channel
            assign sel = word.chan_mask[ch];

            // Input register
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    input_code[ch*CODE_W +: CODE_W] <= CODE_RESET;
                end else if (op_valid && word.opcode == OP_SWRESET) begin
                    input_code[ch*CODE_W +: CODE_W] <= CODE_RESET;
                end else if (op_valid && sel &&
                             (word.opcode == OP_WR_IN || word.opcode == OP_WR_UPD)) begin
                    // unsigned code from top data bits
                    input_code[ch*CODE_W +: CODE_W] <= word.code;
                end
            end

            // Output register
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    dac_code[ch*CODE_W +: CODE_W] <= CODE_RESET;
                end else if (op_valid && word.opcode == OP_SWRESET) begin
                    dac_code[ch*CODE_W +: CODE_W] <= CODE_RESET;
                end else if (op_valid && sel && word.opcode == OP_WR_UPD) begin
                    dac_code[ch*CODE_W +: CODE_W] <= word.code;
                end else if (op_valid && sel && word.opcode == OP_WR_IN &&
                             !ld_q[1] && !load_mask[ch]) begin
                    dac_code[ch*CODE_W +: CODE_W] <= word.code;
                end else if (op_valid && sel && word.opcode == OP_UPDATE) begin
                    dac_code[ch*CODE_W +: CODE_W] <= input_code[ch*CODE_W +: CODE_W];
                end else if (ld_pulse && !load_mask[ch]) begin
                    // Strobe edge loads unmasked channels
                    dac_code[ch*CODE_W +: CODE_W] <= input_code[ch*CODE_W +: CODE_W];
                end
            end

            // Power mode, two bits per channel from low eight code bits
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    power_mode[ch*2 +: 2] <= PD_NORMAL;
                end else if (op_valid && word.opcode == OP_SWRESET) begin
                    power_mode[ch*2 +: 2] <= PD_NORMAL;
                end else if (op_valid && sel && word.opcode == OP_POWER) begin
                    power_mode[ch*2 +: 2] <= {word.code[2*ch+1], word.code[2*ch]};
                end
            end
        end
    endgenerate
endmodule

/* hdl/qdac_pkg.sv */
// Purpose: shared constants and carriers for the quad converter command front end
// Assumes: core clock 100 MHz, bus pins sampled through two flip-flops
// Notes:   channel order is A in bit 0 up to D in bit 3
package qdac_pkg;
    localparam int          NCH         = 4;
    localparam int          CODE_W      = 10;
    localparam int          WORD_W      = 24;
    localparam int          BYTES_PER_WORD = 3;
    localparam logic [4:0]  ADDR_FIXED  = 5'h03;
    localparam logic [9:0]  CODE_RESET  = 10'h000;
    localparam logic [1:0]  PD_NORMAL   = 2'h0;
    localparam logic        REF_RESET_DIS = 1'b0;
    localparam logic [3:0]  MASK_RESET  = 4'h0;
    // Opcodes
    localparam logic [3:0]  OP_NOP      = 4'h0;
    localparam logic [3:0]  OP_WR_IN    = 4'h1;
    localparam logic [3:0]  OP_UPDATE   = 4'h2;
    localparam logic [3:0]  OP_WR_UPD   = 4'h3;
    localparam logic [3:0]  OP_POWER    = 4'h4;
    localparam logic [3:0]  OP_LDMASK   = 4'h5;
    localparam logic [3:0]  OP_SWRESET  = 4'h6;
    localparam logic [3:0]  OP_REFSET   = 4'h7;

    // One received word
    typedef struct packed {
        logic [3:0]  opcode;
        logic [3:0]  chan_mask;
        logic [9:0]  code;
        logic [5:0]  spare;
    } cmd_word_s;
endpackage

/* hdl/i2c_word_rx.sv */
// Purpose: I2C slave receiver that collects 24-bit write words
// Assumes: scl and sda already synchronised into core_clk
// Notes:   read addresses get no acknowledge and the frame is skipped
`timescale 1ns/1ps
module i2c_word_rx
    import qdac_pkg::*;
(
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            nrst,
    // Synchronised bus levels
    input  wire logic            scl_s,
    input  wire logic            sda_s,
    input  wire logic [1:0]      addr_pins,
    // Open-drain data drive, low enable pulls line low
    output logic                 sda_oe_n,
    // Received word
    output cmd_word_s            word,
    output logic                 word_stb
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_ACK  = 5'b01000,
        ST_SKIP = 5'b10000
    } rx_state_e;

    rx_state_e         state_r;       // Receiver state
    logic              scl_d_r;       // Previous clock level
    logic              sda_d_r;       // Previous data level
    logic [3:0]        bitcnt_r;      // Bits of current byte
    logic [7:0]        sh_r;          // Byte shifter
    logic [1:0]        bytecnt_r;     // Bytes of current word
    logic [23:0]       acc_r;         // Word accumulator
    logic              ack_pend_r;    // Ack owed after byte
    logic              word_done_r;   // Third byte taken
    logic              start_c, stop_c, scl_rise, scl_fall;

    assign start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;

    // Edge history
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Protocol sequencer
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r     <= ST_IDLE;
            bitcnt_r    <= 4'h0;
            sh_r        <= 8'h00;
            bytecnt_r   <= 2'h0;
            acc_r       <= '0;
            ack_pend_r  <= 1'b0;
            sda_oe_n    <= 1'b1;
            word_done_r <= 1'b0;
            word_stb    <= 1'b0;
            word        <= '0;
        end else begin
            word_stb <= 1'b0;
            if (start_c) begin
                state_r   <= ST_ADDR;
                bitcnt_r  <= 4'h0;
                bytecnt_r <= 2'h0;
                sda_oe_n  <= 1'b1;
                word_done_r <= 1'b0;
            end else if (stop_c) begin
                state_r  <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end else begin
                unique case (state_r)
                    ST_IDLE, ST_SKIP: begin
                        sda_oe_n <= 1'b1;
                    end
                    ST_ADDR, ST_DATA: begin
                        // Sample while clock high, on rising edge
                        if (scl_rise) begin
                            sh_r     <= {sh_r[6:0], sda_s};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                        if (scl_fall && bitcnt_r == 4'h8) begin
                            bitcnt_r <= 4'h0;
                            state_r  <= ST_ACK;
                            if (state_r == ST_ADDR) begin
                                ack_pend_r <= (sh_r[7:1] == {ADDR_FIXED, addr_pins}) && !sh_r[0];
                                sda_oe_n   <= !((sh_r[7:1] == {ADDR_FIXED, addr_pins}) && !sh_r[0]);
                            end else begin
                                acc_r      <= {acc_r[15:0], sh_r};
                                ack_pend_r <= 1'b1;
                                sda_oe_n   <= 1'b0;
                                word_done_r <= (bytecnt_r == 2'(BYTES_PER_WORD - 1));
                                bytecnt_r  <= (bytecnt_r == 2'(BYTES_PER_WORD - 1)) ? 2'h0 : bytecnt_r + 2'h1;
                            end
                        end
                    end
                    ST_ACK: begin
                        // Release after acknowledge clock
                        if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            state_r  <= ack_pend_r ? ST_DATA : ST_SKIP;
                            if (word_done_r) begin
                                word        <= cmd_word_s'(acc_r);
                                word_stb    <= 1'b1;
                                word_done_r <= 1'b0;
                            end
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* verif/quad_dac_i2c_command_decoder_assertions.sv */
// Purpose: concurrent checks on the command decoder's ports
// Assumes: one core_clk domain, bus far slower than the core
// Notes:   bound into the design top below the module
`timescale 1ns/1ps
module qdac_cmd_checker
    import qdac_pkg::*;
(
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 nrst,
    // Bus pins
    input wire logic                 scl_in,
    input wire logic                 sda_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe_n,
    // Straps and controls
    input wire logic                 addr_select_hi,
    input wire logic                 addr_select_lo,
    input wire logic                 load_strobe_n,
    input wire logic                 gain_sel,
    // Converter side
    input wire logic [NCH*CODE_W-1:0] dac_code,
    input wire logic [NCH*CODE_W-1:0] input_code,
    input wire logic [NCH*2-1:0]     power_mode,
    input wire logic                 ref_disable,
    input wire logic                 gain_two,
    input wire logic [NCH-1:0]       load_mask
);
    // All checks share the core clock; all but the two reset checks share the reset disable
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Reset checks must run while reset is low
    a_reset_state: assert property (
        disable iff (1'b0) !nrst |=> dac_code == '0 && input_code == '0 && power_mode == '0 && load_mask == '0)
        else $error("state not cleared by reset");
    a_reset_ref: assert property (
        disable iff (1'b0) !nrst |=> !ref_disable && sda_oe_n)
        else $error("reference or ack not idle after reset");
    // Sync delay kept inside a small window
    a_gain_follow: assert property (
        !$stable(gain_sel) |-> ##[1:4] gain_two == gain_sel)
        else $error("gain output does not follow pin");
    a_drive_zero: assert property (
        !sda_oe_n |-> !sda_out)
        else $error("data driven high while enabled");
    // Ack may only move while the bus clock is low
    a_ack_start: assert property (
        $fell(sda_oe_n) |-> !scl_in)
        else $error("ack started during clock high");
    a_ack_release: assert property (
        $rose(sda_oe_n) |-> !scl_in)
        else $error("ack released during clock high");
    a_ack_held: assert property (
        !sda_oe_n && $rose(scl_in) |=> !sda_oe_n [*8])
        else $error("ack dropped in clock high");
    // Words only take effect after the final ack clock falls
    a_input_idle: assert property (
        !$stable(input_code) |-> !scl_in)
        else $error("input code changed mid bit");
    a_dac_idle: assert property (
        !$stable(dac_code) |-> !scl_in || !load_strobe_n)
        else $error("output code changed mid bit");
    a_ctrl_idle: assert property (
        !$stable({power_mode, ref_disable, load_mask}) |-> !scl_in)
        else $error("control state changed mid bit");
    a_pass_through: assert property (
        !load_strobe_n && !load_mask[0] && !$stable(input_code[9:0]) |-> ##[0:4] dac_code[9:0] == input_code[9:0])
        else $error("low strobe did not pass channel A through");

    // Main scenarios reached
    c_ack: cover property ($fell(sda_oe_n));
    c_dac_update: cover property (!$stable(dac_code));
    c_ref_off: cover property ($rose(ref_disable));
endmodule

bind quad_dac_i2c_command_decoder qdac_cmd_checker chk_u (
    .core_clk, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe_n, .addr_select_hi, .addr_select_lo,
    .load_strobe_n, .gain_sel, .dac_code, .input_code, .power_mode, .ref_disable, .gain_two, .load_mask
);

/* verif/qdac_i2c_master.sv */
// Purpose: behavioural bus master facing the decoder
// Assumes: pull-up on the data line, clock idles high
// Notes:   changes land on the falling core edge only
`timescale 1ns/1ps
module qdac_i2c_master (
    // Core timing reference
    input wire logic core_clk,
    // Device side of the data line
    input wire logic sda_oe_n,
    input wire logic sda_out,
    // Bus lines
    output logic     scl,
    output logic     sda
);
    localparam int HALF = 125;
    logic sda_drv;  // Own open-drain drive, 1 = released

    // Wired-and with pull-up, released line reads high
    assign sda = sda_drv & (sda_oe_n | sda_out);

    // Bus idle at time zero
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic start;
        wait_clk(HALF);
        sda_drv = 1'b0;
        wait_clk(HALF);
        scl = 1'b0;
    endtask

    task automatic bit_cycle(input logic b, output logic seen);
        wait_clk(HALF / 2);
        sda_drv = b;
        wait_clk(HALF - HALF / 2);
        scl = 1'b1;
        wait_clk(HALF - 4);
        seen = sda;  // Sampled late, after any ack settles
        wait_clk(4);
        scl = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, ack);
    endtask

    // Stop: data rises while clock high
    task automatic stop;
        wait_clk(HALF / 2);
        sda_drv = 1'b0;
        wait_clk(HALF / 2);
        scl = 1'b1;
        wait_clk(HALF);
        sda_drv = 1'b1;
        wait_clk(HALF);
    endtask
endmodule

/* verif/quad_dac_i2c_command_decoder_tb_top.sv */
// Purpose: directed bench for the quad converter command decoder
// Assumes: bus master model drives the serial pins
// Notes:   whole run is roughly 89k core cycles at 400 kHz
`timescale 1ns/1ps
module quad_dac_i2c_command_decoder_tb_top import qdac_pkg::*;;
    logic                   core_clk, nrst, addr_select_hi, addr_select_lo, load_strobe_n, gain_sel;
    logic                   scl, sda, sda_out, sda_oe_n, gain_two, ref_disable, ack;
    logic [NCH*CODE_W-1:0]  dac_code, input_code;
    logic [NCH*2-1:0]       power_mode;
    logic [NCH-1:0]         load_mask;
    int                     err_count, samples_checked;
    // Device strapped to address pins 1,0
    localparam logic [6:0]  DEV = {ADDR_FIXED, 2'b10};

    // 100 MHz core clock
    always #5 core_clk = ~core_clk;

    quad_dac_i2c_command_decoder dut_u (
        .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .addr_select_hi(addr_select_hi), .addr_select_lo(addr_select_lo),
        .load_strobe_n(load_strobe_n), .gain_sel(gain_sel), .dac_code(dac_code), .input_code(input_code),
        .power_mode(power_mode), .ref_disable(ref_disable), .gain_two(gain_two), .load_mask(load_mask));
    qdac_i2c_master m_u (.core_clk(core_clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl(scl), .sda(sda));

    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Start plus address byte with write bit
    task automatic open_xfer(input logic [6:0] a, input logic exp);
        m_u.start();
        m_u.put_byte({a, 1'b0}, ack);
        chk("addr_ack", 40'(exp), 40'(ack));
    endtask

    // One word, command then high then low byte
    task automatic send(input logic [23:0] w);
        for (int i = 2; i >= 0; i--) begin
            m_u.put_byte(w[8*i+:8], ack);
            chk("data_ack", 40'h0, 40'(ack));
        end
    endtask

    task automatic settle;
        m_u.stop();
        repeat (20) @(negedge core_clk);
    endtask

    // Main sequence
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        {addr_select_hi, addr_select_lo} = 2'b10;
        load_strobe_n = 1'b1;
        gain_sel = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("dac_rst", 40'h0, dac_code);
        chk("ctrl_rst", 40'h0, 40'({power_mode, load_mask, ref_disable, gain_two, ~sda_oe_n}));
        gain_sel = 1'b1;
        repeat (10) @(negedge core_clk);
        chk("gain", 40'h1, 40'(gain_two));
        // Write-and-update on A and C, then input-only on B
        open_xfer(DEV, 1'b0);
        send(24'h35ffc0);
        send(24'h125540);
        settle();
        chk("dac_t1", {10'h0, 10'h3ff, 10'h0, 10'h3ff}, dac_code);
        chk("in_b", 40'h155, 40'(input_code[19:10]));
        // Update B, reserved, empty mask, power modes
        open_xfer(DEV, 1'b0);
        send(24'h220000);
        send(24'h8f0000);
        send(24'h700001);
        send(24'h4f0e40);
        settle();
        chk("dac_t2", {10'h0, 10'h3ff, 10'h155, 10'h3ff}, dac_code);
        chk("ctrl_t2", 40'h720, 40'({power_mode, ref_disable, load_mask}));
        // Foreign and general call addresses get no ack
        open_xfer(7'h00, 1'b1);
        m_u.stop();
        open_xfer({ADDR_FIXED, 2'b01}, 1'b1);
        m_u.stop();
        // Strobe low, reference off, mask C, write A, then a cut word
        load_strobe_n = 1'b0;
        repeat (10) @(negedge core_clk);
        open_xfer(DEV, 1'b0);
        send(24'h7f0001);
        send(24'h540000);
        send(24'h11aa80);
        m_u.put_byte(8'h3f, ack);
        m_u.put_byte(8'hff, ack);
        settle();
        chk("dac_ab", 40'({10'h155, 10'h2aa}), 40'(dac_code[19:0]));
        chk("dac_d", 40'h0, 40'(dac_code[39:30]));
        chk("ctrl_t4", 40'h734, 40'({power_mode, ref_disable, load_mask}));
        // Software reset restores power-up state
        open_xfer(DEV, 1'b0);
        send(24'h6f0000);
        settle();
        chk("dac_sw", 40'h0, dac_code);
        chk("in_sw", 40'h0, input_code);
        chk("ctrl_sw", 40'h0, 40'({power_mode, ref_disable, load_mask}));
        report_and_stop();
    end

    // Watchdog sized above the expected run length
    initial begin
        repeat (110000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end
endmodule
